// *** bench/fbl_host_model.sv ***
// Behavioural host at the far end of the boot serial link
`timescale 1ns/1ps
module fbl_host_model #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic pclk,
  // Serial link
  input wire logic txd,
  output logic rxd
);
  // Board pull-up keeps the line high between frames
  initial rxd = 1'b1;

  // Start bit, 8 data bits LSB first, one stop bit, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= fr[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask

  // Samples mid-bit at the host's own rate
  task automatic recv_byte(output logic [7:0] b);
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      b[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
  endtask

  // One byte per call, sending it while waiting for its echo before the next
  task automatic xfer(input logic [7:0] b, output logic [7:0] e);
    fork
      send_byte(b);
      recv_byte(e);
    join
  endtask
endmodule

// *** bench/fbl_loader_tb_top.sv ***
// Self-checking bench for the flash boot mode loader
`timescale 1ns/1ps
module fbl_loader_tb_top
  import fbl_pkg::*;
;
  localparam int BIT = 16;
  localparam fbl_pins_t PINS_USER = 6'b010000;
  localparam fbl_pins_t PINS_BOOT = 6'b001000;
  localparam fbl_pins_t PINS_PROG = 6'b100000;
  logic pclk, presetn, psel, penable, pwrite;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  fbl_pins_t mode_pins;
  logic subactive_mode, watchdog_overflow, flash_powerdown;
  fbl_mode_t mode;
  logic rxd, txd, txd_oe, erase_req, erase_done, erase_fail, boot_branch;
  fbl_ram_t ram_wr;
  int n_mismatch;
  int compares;
  logic [15:0] ram_a[$];
  logic [7:0] ram_d[$];

  fbl_loader i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_pins(mode_pins), .subactive_mode(subactive_mode),
    .watchdog_overflow(watchdog_overflow), .mode(mode), .flash_powerdown(flash_powerdown),
    .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .erase_req(erase_req), .erase_done(erase_done),
    .erase_fail(erase_fail), .ram_wr(ram_wr), .boot_branch(boot_branch));
  fbl_host_model #(.BIT(BIT)) i_host (.pclk(pclk), .txd(txd), .rxd(rxd));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Bench only watches loader RAM writes, never touches that RAM
  always @(posedge pclk) begin
    if (ram_wr.we === 1'b1) begin
      ram_a.push_back(ram_wr.addr);
      ram_d.push_back(ram_wr.data);
    end
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1, "bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, xe}, "slave error");
  endtask

  task automatic do_reset(input fbl_pins_t p, input int hold);
    presetn <= 1'b0;
    mode_pins <= p;
    repeat (hold) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
  endtask

  task automatic pd_chk(input logic exp);
    repeat (4) @(posedge pclk);
    #1;
    chk({31'h0, flash_powerdown}, {31'h0, exp}, "power down");
  endtask

  // Rate match, handshake and erase result
  task automatic boot_to_erase(input logic fail, input logic [7:0] exp);
    logic [7:0] r;
    int n;
    n = 0;
    repeat (120) @(posedge pclk);
    i_host.xfer(BYTE_SYNC, r);
    chk({24'h0, r}, {24'h0, BYTE_SYNC}, "sync reply");
    i_host.send_byte(BYTE_ACK);
    while (erase_req !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, erase_req}, 32'h1, "erase request");
    fork
      i_host.recv_byte(r);
      begin
        @(posedge pclk);
        erase_fail <= fail;
        erase_done <= ~fail;
        @(posedge pclk);
        erase_fail <= 1'b0;
        erase_done <= 1'b0;
      end
    join
    chk({24'h0, r}, {24'h0, exp}, "erase result");
  endtask

  initial begin
    logic [7:0] r;
    logic [31:0] s;
    logic e;
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mode_pins = PINS_USER;
    subactive_mode = 1'b0;
    watchdog_overflow = 1'b0;
    erase_done = 1'b0;
    erase_fail = 1'b0;
    n_mismatch = 0;
    compares = 0;
    do_reset(PINS_USER, 4);
    chk({28'h0, mode}, {28'h0, MODE_USER}, "user mode");
    rd_chk(OFF_FEN, 32'h0, 1'b0);
    wr(OFF_FCTL1, 8'h40);
    rd_chk(OFF_FCTL1, 32'h0, 1'b0);
    wr(OFF_FEN, 8'hff);
    rd_chk(OFF_FEN, 32'h80, 1'b0);
    wr(OFF_FCTL1, 8'hff);
    rd_chk(OFF_FCTL1, 32'h7f, 1'b0);
    wr(OFF_EBLK, 8'h01);
    rd_chk(OFF_EBLK, 32'h01, 1'b0);
    wr(OFF_FSTAT, 8'hff);
    rd_chk(OFF_FSTAT, 32'h0, 1'b0);
    rd_chk(8'h20, 32'h0, 1'b1);
    wr(OFF_FPWR, 8'hff);
    rd_chk(OFF_FPWR, 32'h80, 1'b0);
    subactive_mode <= 1'b1;
    pd_chk(1'b0);
    wr(OFF_FPWR, 8'h00);
    pd_chk(1'b1);
    wr(OFF_FEN, 8'h00);
    wr(OFF_FPWR, 8'h80);
    pd_chk(1'b1);
    rd_chk(OFF_FPWR, 32'h0, 1'b0);
    subactive_mode <= 1'b0;
    pd_chk(1'b0);
    do_reset(PINS_PROG, 4);
    chk({28'h0, mode}, {28'h0, MODE_PROG}, "programmer mode");
    do_reset(PINS_BOOT, 24);
    chk({28'h0, mode}, {28'h0, MODE_BOOT}, "boot mode");
    boot_to_erase(1'b1, BYTE_FAIL);
    watchdog_overflow <= 1'b1;
    @(posedge pclk);
    watchdog_overflow <= 1'b0;
    #1;
    chk({28'h0, mode}, {28'h0, MODE_UNSET}, "watchdog reset");
    @(posedge pclk);
    #1;
    chk({28'h0, mode}, {28'h0, MODE_BOOT}, "boot again");
    boot_to_erase(1'b0, BYTE_OK);
    i_host.xfer(8'h00, r);
    chk({24'h0, r}, 32'h00, "length high echo");
    i_host.xfer(8'h03, r);
    chk({24'h0, r}, 32'h03, "length low echo");
    for (int i = 0; i < 3; i++) begin
      i_host.xfer(8'ha5 ^ 8'(i * 8'h3c), r);
      chk({24'h0, r}, {24'h0, 8'ha5 ^ 8'(i * 8'h3c)}, "data echo");
    end
    n = 0;
    while (boot_branch !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, boot_branch}, 32'h1, "branch");
    chk({31'h0, txd}, 32'h1, "transmit line high");
    chk({31'h0, txd_oe}, 32'h1, "transmit driven");
    chk(ram_a.size(), 32'd3, "ram writes");
    for (int i = 0; i < ram_a.size(); i++) begin
      chk({16'h0, ram_a[i]}, {16'h0, RAM_BASE + 16'(i)}, "ram address");
      chk({24'h0, ram_d[i]}, {24'h0, 8'ha5 ^ 8'(i * 8'h3c)}, "ram data");
    end
    apb(1'b0, OFF_LDST, 32'h0, s, e);
    chk({27'h0, s[4:0]}, {27'h0, 1'b1, MODE_BOOT}, "loader status");
    chk({31'h0, s[31:14] >= BIT - 1 && s[31:14] <= BIT + 1}, 32'h1, "divisor kept");
    end_sim;
  end

  initial begin
    #80000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    end_sim;
  end
endmodule

// *** hw/fbl_loader.sv ***
// Flash boot mode loader with APB flash register gate
`timescale 1ns/1ps
module fbl_loader
  import fbl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode pins and system events
  input wire fbl_pins_t mode_pins,
  input wire logic subactive_mode,
  input wire logic watchdog_overflow,
  output fbl_mode_t mode,
  output logic flash_powerdown,
  // Boot serial link
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  // Flash erase engine
  output logic erase_req,
  input wire logic erase_done,
  input wire logic erase_fail,
  // RAM write port and branch
  output fbl_ram_t ram_wr,
  output logic boot_branch
);

  fbl_state_t s, n;
  logic gate;

  assign gate = s.flash_register_access_enable[GATE_BIT];

  function automatic fbl_state_t send(input fbl_state_t st, input logic [7:0] b);
    fbl_state_t r;
    r = st;
    r.tx_busy = 1'b1;
    r.tx_sh = {1'b1, b, 1'b0};
    r.tx_idx = '0;
    r.tx_cnt = st.baud - 1'b1;
    r.txd = 1'b0;
    return r;
  endfunction

  function automatic fbl_mode_t mode_of(input fbl_pins_t p);
    fbl_mode_t m;
    m = MODE_USER;
    if (!p.test_pin && !p.irq_pin_n && p.port8_bit5_pin) begin
      m = MODE_BOOT;
    end else if (p.test_pin && !p.portb_bit0_pin && !p.portb_bit1_pin
                 && !p.portb_bit2_pin) begin
      m = MODE_PROG;
    end
    return m;
  endfunction

  always_comb begin
    n = s;
    n.rx_s1 = rxd;
    n.rx_s2 = s.rx_s1;
    n.rx_vld = 1'b0;
    n.ram.we = 1'b0;
    // Mode decode on the first edge after reset release
    if (s.mode == MODE_UNSET) begin
      n.mode = mode_of(mode_pins);
      if (n.mode == MODE_BOOT) begin
        n.ld = LD_WAIT;
        n.wait_cnt = '0;
        n.txd_oe = 1'b1;
      end
    end
    // Receiver, start bit checked at mid-bit, LSB first
    if (!s.sci_re) begin
      n.rx_busy = 1'b0;
    end else if (!s.rx_busy) begin
      if (!s.rx_s2) begin
        n.rx_busy = 1'b1;
        n.rx_cnt = s.baud >> 1;
        n.rx_idx = '0;
      end
    end else if (s.rx_cnt != '0) begin
      n.rx_cnt = s.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = s.baud - 1'b1;
      n.rx_idx = s.rx_idx + 4'h1;
      if (s.rx_idx == '0) begin
        n.rx_busy = !s.rx_s2;
      end else if (s.rx_idx <= DATA_BITS) begin
        n.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
      end else begin
        // Framing error drops the byte silently
        n.rx_busy = 1'b0;
        n.rx_vld = s.rx_s2;
        n.rx_byte = s.rx_sh;
      end
    end
    // Transmitter
    if (s.tx_busy) begin
      if (s.tx_cnt != '0) begin
        n.tx_cnt = s.tx_cnt - 1'b1;
      end else if (s.tx_idx == FRAME_LAST) begin
        n.tx_busy = 1'b0;
        n.txd = 1'b1;
      end else begin
        n.tx_sh = s.tx_sh >> 1;
        n.txd = s.tx_sh[1];
        n.tx_idx = s.tx_idx + 4'h1;
        n.tx_cnt = s.baud - 1'b1;
      end
    end
    // Boot sequence
    case (s.ld)
      LD_OFF: begin
      end
      LD_WAIT: begin
        if (s.wait_cnt == 8'(BOOT_WAIT_CYC - 1)) begin
          n.ld = LD_ARM;
        end else begin
          n.wait_cnt = s.wait_cnt + 8'h01;
        end
      end
      LD_ARM: begin
        if (s.rx_s2) begin
          n.ld = LD_HUNT;
        end
      end
      LD_HUNT: begin
        if (!s.rx_s2) begin
          n.ld = LD_MEAS;
          n.pre = 4'h1;
          n.div = '0;
        end
      end
      LD_MEAS: begin
        // Nine low bit times per zero byte; prescaler divides by nine
        if (!s.rx_s2) begin
          if (s.pre == RATE_BITS - 4'h1) begin
            n.pre = '0;
            n.div = s.div + 1'b1;
          end else begin
            n.pre = s.pre + 4'h1;
          end
        end else begin
          n.baud = (s.div == '0) ? BAUD_W'(1) : s.div;
          n.sci_te = 1'b1;
          n.ld = LD_TX_ADJ;
        end
      end
      LD_TX_ADJ: begin
        n = send(n, BYTE_SYNC);
        n.sci_re = 1'b1;
        n.ld = LD_WAIT_ACK;
      end
      LD_WAIT_ACK: begin
        // Trailing zero bytes from the host are ignored here
        if (s.rx_vld && s.rx_byte == BYTE_ACK) begin
          n.ld = LD_ERASE;
        end
      end
      LD_ERASE: begin
        if (erase_fail) begin
          n = send(n, BYTE_FAIL);
          n.fler = 1'b1;
          n.ld = LD_ABORT;
        end else if (erase_done) begin
          n = send(n, BYTE_OK);
          n.ld = LD_LEN_HI;
        end
      end
      LD_LEN_HI: begin
        if (s.rx_vld) begin
          n = send(n, s.rx_byte);
          n.len[15:8] = s.rx_byte;
          n.ld = LD_LEN_LO;
        end
      end
      LD_LEN_LO: begin
        if (s.rx_vld) begin
          n = send(n, s.rx_byte);
          n.len[7:0] = s.rx_byte;
          n.got = '0;
          n.ld = ({s.len[15:8], s.rx_byte} == '0) ? LD_DRAIN : LD_DATA;
        end
      end
      LD_DATA: begin
        if (s.rx_vld) begin
          n = send(n, s.rx_byte);
          // Bytes past the RAM window are echoed but not stored
          n.ram.we = (s.got <= RAM_SPAN);
          n.ram.addr = RAM_BASE + s.got;
          n.ram.data = s.rx_byte;
          n.got = s.got + 16'h0001;
          if (s.got + 16'h0001 == s.len) begin
            n.ld = LD_DRAIN;
          end
        end
      end
      LD_DRAIN: begin
        if (!s.tx_busy) begin
          n.sci_re = 1'b0;
          n.sci_te = 1'b0;
          n.txd = 1'b1;
          n.branch = 1'b1;
          n.ld = LD_BRANCH;
        end
      end
      LD_BRANCH, LD_ABORT: begin
      end
      default: begin
        n.ld = LD_OFF;
      end
    endcase
    n.erase_req = (n.ld == LD_ERASE);
    if (watchdog_overflow) begin
      n = ST_RST;
    end
    // APB: answer registered in setup, so access phase has no wait state
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr)
        OFF_FCTL1: begin
          if (gate) n.prdata[7:0] = s.fctl1;
        end
        OFF_FSTAT: begin
          if (gate) n.prdata[FLER_BIT] = s.fler;
        end
        OFF_EBLK: begin
          if (gate) n.prdata[7:0] = s.eblk;
        end
        OFF_FPWR: begin
          if (gate) n.prdata[7:0] = s.fpwr & TOP_MASK;
        end
        OFF_FEN: begin
          n.prdata[7:0] = s.flash_register_access_enable & TOP_MASK;
        end
        OFF_LDST: begin
          n.prdata = {s.baud, 8'h00, s.fler, s.branch, s.mode};
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && s.pready && pwrite) begin
      case (paddr)
        OFF_FCTL1: begin
          if (gate) n.fctl1 = pwdata[7:0] & FCTL1_MASK;
        end
        OFF_EBLK: begin
          if (gate) n.eblk = pwdata[7:0] & EBLK_MASK;
        end
        OFF_FPWR: begin
          if (gate) n.fpwr = pwdata[7:0] & TOP_MASK;
        end
        OFF_FEN: begin
          n.flash_register_access_enable = pwdata[7:0] & TOP_MASK;
        end
        default: begin
        end
      endcase
    end
    if (!n.fctl1[SWE_BIT]) begin
      n.eblk = REG_RST;
    end
    n.pdown = subactive_mode && !s.fpwr[INHIBIT_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign mode = s.mode;
  assign flash_powerdown = s.pdown;
  assign txd = s.txd;
  assign txd_oe = s.txd_oe;
  assign erase_req = s.erase_req;
  assign ram_wr = s.ram;
  assign boot_branch = s.branch;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pdown;
    subactive_mode && !s.fpwr[INHIBIT_BIT] |=> flash_powerdown;
  endproperty
  a_pdown: assert property (p_pdown) else $error("powerdown not entered");

  property p_rsv;
    s.fpwr[6:0] == '0 && s.flash_register_access_enable[6:0] == '0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");

  property p_gate_rd;
    psel && !penable && !gate && paddr == OFF_FCTL1 |=> prdata == '0 && pready;
  endproperty
  a_gate_rd: assert property (p_gate_rd) else $error("gated read leaked");

  property p_gate_wr;
    psel && penable && pready && pwrite && !gate && paddr == OFF_FPWR
      |=> $stable(s.fpwr);
  endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gated write took");

  property p_mode;
    s.mode == MODE_UNSET && !watchdog_overflow && !mode_pins.test_pin
      && !mode_pins.irq_pin_n && mode_pins.port8_bit5_pin |=> mode == MODE_BOOT;
  endproperty
  a_mode: assert property (p_mode) else $error("boot mode not taken");

  property p_wait;
    $fell(s.ld == LD_WAIT) && !$past(watchdog_overflow)
      |-> $past(s.wait_cnt) == 8'(BOOT_WAIT_CYC - 1);
  endproperty
  a_wait: assert property (p_wait) else $error("start delay wrong");

  property p_rate;
    s.ld == LD_MEAS && s.rx_s2 && s.div != '0 && !watchdog_overflow
      |=> s.baud == $past(s.div);
  endproperty
  a_rate: assert property (p_rate) else $error("divisor not set");

  property p_adj;
    s.ld == LD_TX_ADJ && !watchdog_overflow
      |=> s.tx_busy && s.tx_sh[8:1] == BYTE_SYNC && !txd;
  endproperty
  a_adj: assert property (p_adj) else $error("sync byte not sent");

  property p_ram;
    ram_wr.we |-> ram_wr.addr >= RAM_BASE && ram_wr.addr <= RAM_LAST;
  endproperty
  a_ram: assert property (p_ram) else $error("RAM write out of window");

  property p_branch;
    $rose(boot_branch) |-> !s.sci_re && !s.sci_te && txd && txd_oe;
  endproperty
  a_branch: assert property (p_branch) else $error("branch state wrong");

  property p_wdt;
    watchdog_overflow |=> s.ld == LD_OFF && mode == MODE_UNSET && !boot_branch;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not end boot");

  property p_fail;
    s.ld == LD_ERASE && erase_fail && !watchdog_overflow
      |=> s.ld == LD_ABORT && s.tx_sh[8:1] == BYTE_FAIL ##1 !erase_req;
  endproperty
  a_fail: assert property (p_fail) else $error("erase failure not reported");

  property p_echo;
    s.ld == LD_DATA && s.rx_vld && !s.tx_busy && !watchdog_overflow
      |=> s.tx_busy && s.tx_sh[8:1] == $past(s.rx_byte);
  endproperty
  a_echo: assert property (p_echo) else $error("byte not echoed");

  c_branch: cover property ($rose(boot_branch));
  c_abort: cover property ($rose(s.ld == LD_ABORT));
  c_pdown: cover property ($rose(flash_powerdown));
  c_gated: cover property (psel && penable && pready && gate && paddr == OFF_FCTL1);

endmodule

// *** include/fbl_pkg.sv ***
// Constants and types for the flash boot mode loader
// Notes on behaviour
// - Inhibit bit 0: flash powers down in subactive mode; 1: stays normal.
// - Low seven bits of power control and access enable always read zero.
// - Flash control, status, erase-block and power registers reachable only when gate set.
// - Mode chosen from test, interrupt, port8 and portB pins at reset end.
// - Boot mode: erase flash, then fetch program over serial channel 3 into RAM, then branch.
// - Serial link framing is 8 data bits, one stop bit, no parity.
// - Time low period of zero bytes, derive host rate, set baud divisor.
// - About 100 states after reset before measuring; receive line high then.
// - Device sends one zero byte; host answers 0x55 or resets to retry.
// - Downloaded program lands in RAM from 0xF780 through 0xFEEF.
// - Before branching clear receive and transmit enables, keep divisor, transmit line high.
// - Watchdog overflow ends boot mode just like a reset.
// - Rate matching works only for suitable host rate and clock pairings.
// - After erase send 0xAA on success; send 0xFF and abort on failure.
// - Length comes as two bytes high first; every length and program byte echoed.
package fbl_pkg;
  localparam int AW = 8;
  localparam int BAUD_W = 18;
  localparam logic [AW-1:0] OFF_FCTL1 = 8'h00;
  localparam logic [AW-1:0] OFF_FSTAT = 8'h04;
  localparam logic [AW-1:0] OFF_EBLK = 8'h08;
  localparam logic [AW-1:0] OFF_FPWR = 8'h0c;
  localparam logic [AW-1:0] OFF_FEN = 8'h10;
  localparam logic [AW-1:0] OFF_LDST = 8'h14;
  localparam int GATE_BIT = 7;
  localparam int INHIBIT_BIT = 7;
  localparam int FLER_BIT = 7;
  localparam int SWE_BIT = 6;
  localparam logic [7:0] FCTL1_MASK = 8'h7f;
  localparam logic [7:0] EBLK_MASK = 8'h1f;
  localparam logic [7:0] TOP_MASK = 8'h80;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int STATE_NS = 4;
  localparam int BOOT_WAIT_STATES = 100;
  localparam int BOOT_WAIT_CYC = BOOT_WAIT_STATES * STATE_NS / 4;
  localparam logic [15:0] RAM_BASE = 16'hf780;
  localparam logic [15:0] RAM_LAST = 16'hfeef;
  localparam logic [15:0] RAM_SPAN = RAM_LAST - RAM_BASE;
  localparam logic [7:0] BYTE_SYNC = 8'h00;
  localparam logic [7:0] BYTE_ACK = 8'h55;
  localparam logic [7:0] BYTE_OK = 8'haa;
  localparam logic [7:0] BYTE_FAIL = 8'hff;
  localparam logic [3:0] RATE_BITS = 4'h9;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] FRAME_LAST = 4'h9;

  typedef enum logic [3:0] {
    MODE_UNSET = 4'b0001, MODE_USER = 4'b0010, MODE_BOOT = 4'b0100, MODE_PROG = 4'b1000
  } fbl_mode_t;

  typedef enum logic [13:0] {
    LD_OFF = 14'h0001, LD_WAIT = 14'h0002, LD_ARM = 14'h0004, LD_HUNT = 14'h0008,
    LD_MEAS = 14'h0010, LD_TX_ADJ = 14'h0020, LD_WAIT_ACK = 14'h0040,
    LD_ERASE = 14'h0080, LD_ABORT = 14'h0100, LD_LEN_HI = 14'h0200,
    LD_LEN_LO = 14'h0400, LD_DATA = 14'h0800, LD_DRAIN = 14'h1000, LD_BRANCH = 14'h2000
  } fbl_ld_t;

  typedef struct packed {
    logic test_pin;
    logic irq_pin_n;
    logic port8_bit5_pin;
    logic portb_bit0_pin;
    logic portb_bit1_pin;
    logic portb_bit2_pin;
  } fbl_pins_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } fbl_ram_t;

  typedef struct packed {
    fbl_mode_t mode;
    fbl_ld_t ld;
    logic [7:0] wait_cnt;
    logic rx_s1;
    logic rx_s2;
    logic [3:0] pre;
    logic [BAUD_W-1:0] div;
    logic [BAUD_W-1:0] baud;
    logic rx_busy;
    logic [BAUD_W-1:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_vld;
    logic [7:0] rx_byte;
    logic tx_busy;
    logic [BAUD_W-1:0] tx_cnt;
    logic [3:0] tx_idx;
    logic [9:0] tx_sh;
    logic txd;
    logic txd_oe;
    logic sci_re;
    logic sci_te;
    logic [15:0] len;
    logic [15:0] got;
    fbl_ram_t ram;
    logic erase_req;
    logic branch;
    logic fler;
    logic [7:0] fctl1;
    logic [7:0] eblk;
    logic [7:0] fpwr;
    logic [7:0] flash_register_access_enable;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic pdown;
  } fbl_state_t;

  localparam fbl_state_t ST_RST = '{mode: MODE_UNSET, ld: LD_OFF, rx_s1: 1'b1,
    rx_s2: 1'b1, txd: 1'b1, default: '0};
endpackage
